// ---- src/timer_compare_unit.sv ----
// output-compare unit with 16-bit timer and AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "tcu_regs.svh"

// Summary of operation
// - the compare value is checked against the timer count and a match drives the pin per mode.
// - the compare match flag is set in the same cycle as the pin action.
// - writing zero to compare control forces the compare output latch low, direction untouched.
// - in software-interrupt mode a match only raises the interrupt, the pin stays as is.
// - in special-event mode a match clears the timer and starts a conversion if enabled.
// - a special-event timer clear never sets the timer overflow flag.
// - with clock select cleared the timer counts the instruction clock.
module timer_compare_unit #(
	parameter int ADDR_W = 12
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic [ADDR_W-1:0] i_awaddr,
	input  wire logic              i_awvalid,
	output logic                   o_awready,
	input  wire tcu_pkg::wpay_t    i_w,
	input  wire logic              i_wvalid,
	output logic                   o_wready,
	output logic [1:0]             o_bresp,
	output logic                   o_bvalid,
	input  wire logic              i_bready,
	input  wire logic [ADDR_W-1:0] i_araddr,
	input  wire logic              i_arvalid,
	output logic                   o_arready,
	output tcu_pkg::rpay_t         o_r,
	output logic                   o_rvalid,
	input  wire logic              i_rready,
	input  wire logic              i_ext_count_pin,
	input  wire logic              i_compare_pin_select_cfg,
	input  wire logic              i_adc_enable,
	output logic                   o_compare_output_pin,
	output logic                   o_compare_output_oe,
	output logic                   o_adc_start,
	output logic                   o_irq
);
	import tcu_pkg::*;

	// ********************************************************
	// register state
	// ********************************************************
	logic [7:0]        intctl_reg;
	logic [7:0]        flags_reg;
	logic [7:0]        flags_next;
	logic [7:0]        tctl_reg;
	logic [7:0]        cctl_reg;
	logic [7:0]        dir_reg;
	logic [7:0]        ena_reg;
	logic [15:0]       timer_count_reg;
	logic [15:0]       timer_count_next;
	logic [15:0]       compare_value_reg;
	logic              cmp_latch_reg;
	logic              cmp_latch_next;
	logic              equal_prev_reg;
	logic [2:0]        pre_reg;
	logic              ext_lvl;
	logic              ext_prev_reg;

	// ********************************************************
	// bus slave state
	// ********************************************************
	logic              aw_full_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic              w_full_reg;
	wpay_t             w_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              rvalid_reg;
	rpay_t             r_reg;

	// handshakes; one write and one read in flight at most
	assign o_awready = ~aw_full_reg & ~bvalid_reg;
	assign o_wready  = ~w_full_reg & ~bvalid_reg;
	assign o_arready = ~rvalid_reg;
	assign o_bvalid  = bvalid_reg;
	assign o_bresp   = bresp_reg;
	assign o_rvalid  = rvalid_reg;
	assign o_r       = r_reg;

	wire aw_fire = i_awvalid & o_awready;
	wire w_fire  = i_wvalid & o_wready;
	wire ar_fire = i_arvalid & o_arready;
	wire wr_go   = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire lane0   = w_reg.strb[0];

	// write decode on the held address
	wire [9:0] wr_idx = 10'(aw_addr_reg[ADDR_W-1:2]);
	wire wr_on     = wr_go & lane0;
	wire wr_intctl = wr_on & (wr_idx == `TCU_IDX_INTCTL);
	wire wr_flags  = wr_on & (wr_idx == `TCU_IDX_FLAGS);
	wire wr_tmrl   = wr_on & (wr_idx == `TCU_IDX_TMRL);
	wire wr_tmrh   = wr_on & (wr_idx == `TCU_IDX_TMRH);
	wire wr_tctl   = wr_on & (wr_idx == `TCU_IDX_TCTL);
	wire wr_cmpl   = wr_on & (wr_idx == `TCU_IDX_CMPL);
	wire wr_cmph   = wr_on & (wr_idx == `TCU_IDX_CMPH);
	wire wr_cctl   = wr_on & (wr_idx == `TCU_IDX_CCTL);
	wire wr_dir    = wr_on & (wr_idx == `TCU_IDX_DIR);
	wire wr_ena    = wr_on & (wr_idx == `TCU_IDX_ENA);
	wire [7:0] wbyte = w_reg.data[7:0];
	wire wr_mapped = wr_intctl | wr_flags | wr_tmrl | wr_tmrh | wr_tctl
		| wr_cmpl | wr_cmph | wr_cctl | wr_dir | wr_ena;
	wire wr_known  = (wr_idx == `TCU_IDX_INTCTL) | (wr_idx == `TCU_IDX_FLAGS)
		| (wr_idx == `TCU_IDX_TMRL) | (wr_idx == `TCU_IDX_TMRH)
		| (wr_idx == `TCU_IDX_TCTL) | (wr_idx == `TCU_IDX_CMPL)
		| (wr_idx == `TCU_IDX_CMPH) | (wr_idx == `TCU_IDX_CCTL)
		| (wr_idx == `TCU_IDX_DIR) | (wr_idx == `TCU_IDX_ENA);

	// read decode; unmapped words read zero with an error answer
	wire [9:0] rd_idx = 10'(i_araddr[ADDR_W-1:2]);
	wire rd_flags = (rd_idx == `TCU_IDX_FLAGS);
	wire rd_known = (rd_idx == `TCU_IDX_INTCTL) | rd_flags
		| (rd_idx == `TCU_IDX_TMRL) | (rd_idx == `TCU_IDX_TMRH)
		| (rd_idx == `TCU_IDX_TCTL) | (rd_idx == `TCU_IDX_CMPL)
		| (rd_idx == `TCU_IDX_CMPH) | (rd_idx == `TCU_IDX_CCTL)
		| (rd_idx == `TCU_IDX_DIR) | (rd_idx == `TCU_IDX_ENA);
	wire [7:0] rd_byte =
		(rd_idx == `TCU_IDX_INTCTL) ? intctl_reg :
		rd_flags                    ? flags_reg :
		(rd_idx == `TCU_IDX_TMRL)   ? timer_count_reg[7:0] :
		(rd_idx == `TCU_IDX_TMRH)   ? timer_count_reg[15:8] :
		(rd_idx == `TCU_IDX_TCTL)   ? tctl_reg :
		(rd_idx == `TCU_IDX_CMPL)   ? compare_value_reg[7:0] :
		(rd_idx == `TCU_IDX_CMPH)   ? compare_value_reg[15:8] :
		(rd_idx == `TCU_IDX_CCTL)   ? cctl_reg :
		(rd_idx == `TCU_IDX_DIR)    ? dir_reg :
		(rd_idx == `TCU_IDX_ENA)    ? ena_reg : 8'h00;

	// ********************************************************
	// timer clocking
	// ********************************************************
	tcu_sync3 u_ext_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_pin   (i_ext_count_pin),
		.o_level (ext_lvl)
	);

	// source tick: every instruction clock, or a filtered pin rise
	wire       t_on     = tctl_reg[`TCU_TCTL_ON];
	wire       t_cs     = tctl_reg[`TCU_TCTL_CS];
	wire [1:0] t_ps     = tctl_reg[`TCU_TCTL_PS_HI:`TCU_TCTL_PS_LO];
	wire       ext_rise = ext_lvl & ~ext_prev_reg;
	wire       src_tick = t_cs ? ext_rise : 1'b1;
	wire [2:0] pre_mask = {t_ps == 2'h3, t_ps[1], t_ps != 2'h0};
	wire       pre_hit  = ((pre_reg & pre_mask) == pre_mask);
	wire       t_inc    = t_on & src_tick & pre_hit;
	wire [2:0] pre_next = (t_on & src_tick) ? (pre_hit ? 3'h0 : pre_reg + 3'h1) : pre_reg;

	// ********************************************************
	// compare logic
	// ********************************************************
	cmp_mode_t mode;
	assign mode = cmp_mode_t'(cctl_reg[3:0]);
	// a match fires once as the count arrives at the compare value
	wire equal     = (timer_count_reg == compare_value_reg);
	wire in_cmp    = (mode == MODE_SET_HI) | (mode == MODE_SET_LO)
		| (mode == MODE_SW_INT) | (mode == MODE_SPECIAL);
	wire match_evt = in_cmp & equal & ~equal_prev_reg;
	wire special   = match_evt & (mode == MODE_SPECIAL);
	// the special clear replaces the wrap, so no overflow is flagged
	wire overflow  = t_inc & (timer_count_reg == 16'hFFFF) & ~special;

	// pin action; interrupt-only and special modes leave the latch alone
	always_comb begin
		cmp_latch_next = cmp_latch_reg;
		if (match_evt && mode == MODE_SET_HI) begin
			cmp_latch_next = 1'b1;
		end else if (match_evt && mode == MODE_SET_LO) begin
			cmp_latch_next = 1'b0;
		end
		if (wr_cctl && wbyte == 8'h00) begin
			cmp_latch_next = 1'b0;
		end
	end

	// timer next value: special clear, then bus write, then increment
	always_comb begin
		timer_count_next = timer_count_reg;
		if (special) begin
			timer_count_next = `TCU_RST_CNT;
		end else if (wr_tmrl) begin
			timer_count_next = {timer_count_reg[15:8], wbyte};
		end else if (wr_tmrh) begin
			timer_count_next = {wbyte, timer_count_reg[7:0]};
		end else if (t_inc) begin
			timer_count_next = timer_count_reg + 16'h0001;
		end
	end

	// sticky flags: set beats clear-on-read and software writes
	wire [7:0] flag_set = (8'(match_evt) << `TCU_FLAG_CMP)
		| (8'(overflow) << `TCU_FLAG_TOV);
	wire [7:0] flag_clr = (ar_fire & rd_flags) ? 8'hFF : 8'h00;
	wire [7:0] flag_imp = (8'h01 << `TCU_FLAG_CMP) | (8'h01 << `TCU_FLAG_TOV);
	always_comb begin
		flags_next = flags_reg & ~flag_clr;
		if (wr_flags) begin
			flags_next = wbyte & flag_imp;
		end
		flags_next = flags_next | flag_set;
	end

	// ********************************************************
	// outputs
	// ********************************************************
	// pin drives only while its selected direction bit is cleared
	wire dir_bit = i_compare_pin_select_cfg ? dir_reg[`TCU_DIR_BIT_B] : dir_reg[`TCU_DIR_BIT_A];
	assign o_compare_output_pin = cmp_latch_reg;
	assign o_compare_output_oe  = ~dir_bit;
	assign o_irq                = |(flags_reg & ena_reg & flag_imp);

	// ********************************************************
	// processes
	// ********************************************************
	// timer, compare and pin state
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			timer_count_reg <= `TCU_RST_CNT;
			cmp_latch_reg   <= 1'b0;
			equal_prev_reg  <= 1'b0;
			pre_reg         <= 3'h0;
			ext_prev_reg    <= 1'b0;
			flags_reg       <= `TCU_RST_FLAGS;
			o_adc_start     <= 1'b0;
		end else begin
			timer_count_reg <= timer_count_next;
			cmp_latch_reg   <= cmp_latch_next;
			equal_prev_reg  <= equal & in_cmp;
			pre_reg         <= pre_next;
			ext_prev_reg    <= ext_lvl;
			flags_reg       <= flags_next;
			o_adc_start     <= special & i_adc_enable;
		end
	end

	// software registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			intctl_reg        <= `TCU_RST_INTCTL;
			tctl_reg          <= `TCU_RST_TCTL;
			cctl_reg          <= `TCU_RST_CCTL;
			dir_reg           <= `TCU_RST_DIR;
			ena_reg           <= `TCU_RST_ENA;
			compare_value_reg <= `TCU_RST_CNT;
		end else begin
			if (wr_intctl) intctl_reg <= wbyte;
			if (wr_tctl) tctl_reg <= wbyte;
			if (wr_cctl) cctl_reg <= wbyte;
			if (wr_dir) dir_reg <= wbyte;
			if (wr_ena) ena_reg <= wbyte;
			if (wr_cmpl) compare_value_reg[7:0] <= wbyte;
			if (wr_cmph) compare_value_reg[15:8] <= wbyte;
		end
	end

	// write channel: address and data held until both are in
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_full_reg  <= 1'b0;
			w_reg       <= '0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `TCU_RESP_OKAY;
		end else begin
			if (aw_fire) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= i_awaddr;
			end
			if (w_fire) begin
				w_full_reg <= 1'b1;
				w_reg      <= i_w;
			end
			if (wr_go) begin
				aw_full_reg <= 1'b0;
				w_full_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_known ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
			end else if (bvalid_reg && i_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// read channel: data captured at the address handshake
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rvalid_reg <= 1'b0;
			r_reg      <= '0;
		end else if (ar_fire) begin
			rvalid_reg <= 1'b1;
			r_reg.data <= {24'h000000, rd_byte};
			r_reg.resp <= rd_known ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
		end else if (rvalid_reg && i_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ********************************************************
	// assertions
	// ********************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_match_flag_set: assert property (match_evt |=> flags_reg[`TCU_FLAG_CMP])
		else $error("match did not set compare flag");
	a_pin_goes_high: assert property ((match_evt && mode == MODE_SET_HI
		&& !(wr_cctl && wbyte == 8'h00)) |=> o_compare_output_pin)
		else $error("set-high match left pin low");
	a_pin_goes_low: assert property ((match_evt && mode == MODE_SET_LO) |=> !o_compare_output_pin)
		else $error("set-low match left pin high");
	a_zero_clears_latch: assert property ((wr_cctl && wbyte == 8'h00) |=> !o_compare_output_pin)
		else $error("zero control write left latch high");
	a_swint_pin_kept: assert property ((match_evt && mode == MODE_SW_INT && !wr_cctl)
		|=> $stable(o_compare_output_pin))
		else $error("interrupt-only match moved the pin");
	a_special_clears: assert property (special |=> timer_count_reg == 16'h0000)
		else $error("special event did not clear timer");
	a_special_adc: assert property ((special && i_adc_enable) |=> o_adc_start)
		else $error("special event did not start conversion");
	a_special_no_ovf: assert property ((special && !flags_reg[`TCU_FLAG_TOV] && !wr_flags)
		|=> !flags_reg[`TCU_FLAG_TOV])
		else $error("special clear set overflow flag");
	a_internal_count: assert property ((t_on && !t_cs && t_ps == 2'h0 && !special
		&& !wr_tmrl && !wr_tmrh) |=> timer_count_reg == $past(timer_count_reg) + 16'h0001)
		else $error("internal clock did not step timer");
	a_bus_answer: assert property (wr_go |=> o_bvalid)
		else $error("write got no response");

	c_match_high: cover property (match_evt && mode == MODE_SET_HI);
	c_special_evt: cover property (special && i_adc_enable);
	c_overflow: cover property (overflow);
	c_irq_raised: cover property (o_irq);
endmodule
`default_nettype wire

// ---- src/tcu_regs.svh ----
// register indices, field positions, reset values of the timer compare unit
`ifndef TCU_REGS_SVH
`define TCU_REGS_SVH
// register indices; byte address is four times the index
`define TCU_IDX_INTCTL  10'h00B
`define TCU_IDX_FLAGS   10'h00C
`define TCU_IDX_TMRL    10'h00E
`define TCU_IDX_TMRH    10'h00F
`define TCU_IDX_TCTL    10'h010
`define TCU_IDX_CMPL    10'h015
`define TCU_IDX_CMPH    10'h016
`define TCU_IDX_CCTL    10'h017
`define TCU_IDX_DIR     10'h086
`define TCU_IDX_ENA     10'h08C
// reset values
`define TCU_RST_INTCTL  8'h00
`define TCU_RST_FLAGS   8'h00
`define TCU_RST_TCTL    8'h00
`define TCU_RST_CCTL    8'h00
`define TCU_RST_DIR     8'hFF
`define TCU_RST_ENA     8'h00
`define TCU_RST_CNT     16'h0000
// field positions
`define TCU_FLAG_TOV    0
`define TCU_FLAG_CMP    2
`define TCU_TCTL_ON     0
`define TCU_TCTL_CS     1
`define TCU_TCTL_PS_LO  4
`define TCU_TCTL_PS_HI  5
`define TCU_DIR_BIT_A   0
`define TCU_DIR_BIT_B   3
// bus answers
`define TCU_RESP_OKAY   2'h0
`define TCU_RESP_SLVERR 2'h2
`endif

// ---- src/tcu_pkg.sv ----
// types shared by the timer compare unit files
package tcu_pkg;
	// compare mode field codes
	typedef enum logic [3:0] {
		MODE_OFF     = 4'h0,
		MODE_SET_HI  = 4'h8,
		MODE_SET_LO  = 4'h9,
		MODE_SW_INT  = 4'hA,
		MODE_SPECIAL = 4'hB
	} cmp_mode_t;
	// write data channel payload
	typedef struct packed {
		logic [31:0] data;
		logic [3:0]  strb;
	} wpay_t;
	// read data channel payload
	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  resp;
	} rpay_t;
endpackage

// ---- src/tcu_sync3.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module tcu_sync3 (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_pin,
	output logic      o_level
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	// first stage feeds only the second; level moves once stages two and three agree
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_reg  <= 1'b0;
			s2_reg  <= 1'b0;
			s3_reg  <= 1'b0;
			o_level <= 1'b0;
		end else begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				o_level <= s3_reg;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/ext_circuit.sv ----
// model of the board circuit on the compare output line and the count input
`timescale 1ns/100ps
`default_nettype none
module ext_circuit (
	input  wire logic i_clk,
	input  wire logic i_pin,
	input  wire logic i_oe,
	output logic      o_line,
	output logic      o_count
);
	// ********************************
	// line level and count source
	// ********************************
	// pull-up holds the line while the direction bit leaves it undriven
	assign o_line = i_oe ? i_pin : 1'b1;
	initial o_count = 1'b0;
	// slow edges, each level held six cycles so the synchroniser never misses one
	task automatic send(input int n);
		repeat (n) begin
			repeat (6) @(posedge i_clk);
			o_count <= 1'b1;
			repeat (6) @(posedge i_clk);
			o_count <= 1'b0;
		end
		repeat (8) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the timer compare unit
`timescale 1ns/100ps
`default_nettype none
`include "tcu_regs.svh"
module tb;
	import tcu_pkg::*;
	// ********************************
	// signals
	// ********************************
	logic        i_clk, i_rst, awvalid, wvalid, bready, arvalid, rready, cfg, adc_en;
	logic [11:0] awaddr, araddr;
	wpay_t       w;
	rpay_t       r;
	logic        awready, wready, bvalid, arready, rvalid, pin, oe, adc_start, irq;
	logic        line, cnt;
	logic [1:0]  bresp, rs;
	logic [7:0]  d;
	int          miscompares, n_checks, i;
	logic [9:0]  ri [6] = '{`TCU_IDX_INTCTL, `TCU_IDX_FLAGS, `TCU_IDX_TCTL,
		`TCU_IDX_CCTL, `TCU_IDX_DIR, `TCU_IDX_ENA};
	logic [7:0]  rv [6] = '{`TCU_RST_INTCTL, `TCU_RST_FLAGS, `TCU_RST_TCTL,
		`TCU_RST_CCTL, `TCU_RST_DIR, `TCU_RST_ENA};

	timer_compare_unit i_timer_compare_unit (.i_clk(i_clk), .i_rst(i_rst),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_w(w),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_r(r), .o_rvalid(rvalid), .i_rready(rready), .i_ext_count_pin(cnt),
		.i_compare_pin_select_cfg(cfg), .i_adc_enable(adc_en),
		.o_compare_output_pin(pin), .o_compare_output_oe(oe), .o_adc_start(adc_start),
		.o_irq(irq));
	ext_circuit i_ext_circuit (.i_clk(i_clk), .i_pin(pin), .i_oe(oe), .o_line(line),
		.o_count(cnt));

	// clock, 50 ns period
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	// ********************************
	// helpers
	// ********************************
	function automatic logic [11:0] ba(input logic [9:0] idx);
		return {idx, 2'b00};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask

	task give_verdict();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// a used-up wait counts as a mismatch and ends the run
	task automatic tmo(input bit bad);
		if (bad) begin
			$display("Error at %0t: wait ran out %h %h", $time, 1'b1, 1'b0);
			miscompares++;
			give_verdict();
		end
	endtask

	// address and data offered together, each dropped at the edge that takes it;
	// a valid left up would be taken again once the response is gone
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		int n;
		@(posedge i_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		w <= '{data: {24'h000000, v}, strb: 4'h1};
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge i_clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		rs = bresp;
		bready <= 1'b0;
		tmo(n == 100);
	endtask

	task automatic rd(input logic [11:0] a);
		int n;
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge i_clk);
			if (arready === 1'b1) break;
		end
		arvalid <= 1'b0;
		tmo(n == 100);
		for (n = 0; n < 100; n++) begin
			@(posedge i_clk);
			if (rvalid === 1'b1) break;
		end
		d = r.data[7:0];
		rs = r.resp;
		rready <= 1'b0;
		tmo(n == 100);
	endtask

	// which: 0 pin (irq must rise with it), 1 conversion start, 2 interrupt
	task automatic wait_for(input int which, input logic v);
		int n;
		logic s;
		for (n = 0; n < 300; n++) begin
			@(posedge i_clk);
			s = (which == 0) ? pin : (which == 1) ? adc_start : irq;
			if (s === v) break;
		end
		tmo(n == 300);
		if (which == 0) chk(irq, 1'b1);
	endtask

	task automatic wait_flag(input logic [7:0] exp);
		int n;
		for (n = 0; n < 50; n++) begin
			rd(ba(`TCU_IDX_FLAGS));
			if (d !== 8'h00) break;
		end
		tmo(n == 50);
		chk(d, exp);
	endtask

	// put the count sixteen ticks below the compare value, then pick the mode
	task automatic arm(input cmp_mode_t m);
		wr(ba(`TCU_IDX_TMRL), 8'h30);
		wr(ba(`TCU_IDX_CCTL), {4'h0, m});
	endtask

	// ********************************
	// main sequence
	// ********************************
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, cfg, adc_en} = '0;
		awaddr = '0;
		araddr = '0;
		w = '0;
		i_rst = 1'b1;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		for (i = 0; i < 6; i++) begin
			rd(ba(ri[i]));
			chk(d, rv[i]);
		end
		rd(12'h000);
		chk({d, rs}, {8'h00, `TCU_RESP_SLVERR});
		wr(12'h004, 8'h5A);
		chk(rs, `TCU_RESP_SLVERR);
		chk(line, 1'b1);
		wr(ba(`TCU_IDX_DIR), 8'hFE);
		chk({rs, oe, line}, {`TCU_RESP_OKAY, 2'b10});
		wr(ba(`TCU_IDX_ENA), 8'h04);
		wr(ba(`TCU_IDX_CMPH), 8'h00);
		wr(ba(`TCU_IDX_CMPL), 8'h40);
		wr(ba(`TCU_IDX_TMRH), 8'h00);
		wr(ba(`TCU_IDX_TCTL), 8'h01);
		arm(MODE_SET_HI);
		wait_for(0, 1'b1);
		rd(ba(`TCU_IDX_FLAGS));
		chk(d, 8'h04);
		chk(irq, 1'b0);
		arm(MODE_SW_INT);
		wait_flag(8'h04);
		chk(pin, 1'b1);
		arm(MODE_SET_LO);
		wait_for(0, 1'b0);
		rd(ba(`TCU_IDX_FLAGS));
		arm(MODE_SET_HI);
		wait_for(0, 1'b1);
		rd(ba(`TCU_IDX_FLAGS));
		wr(ba(`TCU_IDX_CCTL), 8'h00);
		chk({pin, line}, 2'b00);
		rd(ba(`TCU_IDX_DIR));
		chk(d, 8'hFE);
		adc_en <= 1'b1;
		arm(MODE_SPECIAL);
		wait_for(1, 1'b1);
		rd(ba(`TCU_IDX_FLAGS));
		chk(d, 8'h04);
		rd(ba(`TCU_IDX_TMRL));
		chk(d < 8'h20, 1'b1);
		wr(ba(`TCU_IDX_CCTL), 8'h00);
		wr(ba(`TCU_IDX_ENA), 8'h01);
		wr(ba(`TCU_IDX_TMRH), 8'hFF);
		wr(ba(`TCU_IDX_TMRL), 8'hF0);
		wait_for(2, 1'b1);
		wr(ba(`TCU_IDX_ENA), 8'h00);
		chk(irq, 1'b0);
		wr(ba(`TCU_IDX_ENA), 8'h01);
		chk(irq, 1'b1);
		rd(ba(`TCU_IDX_FLAGS));
		chk({d, irq}, {8'h01, 1'b0});
		// external count source, five slow edges
		wr(ba(`TCU_IDX_TCTL), 8'h03);
		wr(ba(`TCU_IDX_TMRH), 8'h00);
		wr(ba(`TCU_IDX_TMRL), 8'h00);
		i_ext_circuit.send(5);
		rd(ba(`TCU_IDX_TMRL));
		chk(d, 8'h05);
		cfg <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk(oe, 1'b0);
		wr(ba(`TCU_IDX_DIR), 8'hF7);
		chk(oe, 1'b1);
		give_verdict();
	end
endmodule
`default_nettype wire
